/* failsafe_fault_reset_control_test.sv */
// Self-checking bench of the fault reaction block.
module failsafe_fault_reset_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ffr_pkg::*;
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, init_ph = 1'b1, cfg_wr = 1'b1, req = 1'b0, stuck = 1'b0;
  logic reg_cor = 1'b0, prom_cor = 1'b0, pin, rst_oe, pg_oe, sh_flag, deep;
  logic pull = 1'b0, pulse_sel = 1'b0, couple = 1'b0, standby = 1'b0, rst_dat, pg_dat, xflag;
  logic [1:0] max_sel = 2'h2;
  logic [1:0] io_uv = 2'h1;
  logic [2:0] pg_asgn = 3'h0;
  logic [1:0] sel_out;
  logic [5:0] mon = 6'h00;
  logic [5:0] mflag;
  logic [3:0] cnt;
  int error_cnt = 0, checks_done = 0, cycles = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  ffr_fault_ctrl dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .failsafe_init_phase_in(init_ph),
    .cfg_write_in(cfg_wr), .fault_counter_max_sel_in(max_sel), .core_ov_reset_impact_in(2'h2),
    .core_uv_reset_impact_in(2'h1), .io_ov_reset_impact_in(2'h2), .io_uv_reset_impact_in(io_uv),
    .aux_ov_reset_impact_in(2'h2), .aux_uv_reset_impact_in(2'h1), .reset_pulse_length_sel_in(pulse_sel),
    .pg_reset_coupling_in(couple), .pg_assign_in(pg_asgn), .monitor_fault_in(mon), .register_corrupt_flag_in(reg_cor),
    .prom_corrupt_flag_in(prom_cor), .reset_request_in(req), .standby_resume_in(standby), .reset_pin_in(pin),
    .reset_out_n_out(rst_dat), .reset_out_n_oe_out(rst_oe), .power_good_n_out(pg_dat), .power_good_n_oe_out(pg_oe),
    .fault_counter_out(cnt), .fault_counter_max_sel_out(sel_out), .monitor_flag_out(mflag),
    .short_high_flag_out(sh_flag), .ext_reset_flag_out(xflag), .deep_failsafe_state_out(deep));
  ffr_host_model host (.reset_oe_in(rst_oe), .stuck_high_in(stuck), .ext_pull_in(pull), .reset_line_out(pin));
  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 100000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic t_startup;
    wait_clk(16);
    chk("reset oe in reset", 6'h1, {5'h0, rst_oe});
    chk("counter in reset", 6'h1, {2'h0, cnt});
    chk("deep in reset", 6'h0, {5'h0, deep});
    rst_n_in = 1'b1;
    wait_clk(2);
    init_ph = 1'b0;
    cfg_wr = 1'b0;
    chk("limit select", 6'h2, {4'h0, sel_out});
    max_sel = 2'h3;
    cfg_wr = 1'b1;
    wait_clk(3);
    cfg_wr = 1'b0;
    chk("limit after late write", 6'h2, {4'h0, sel_out});
    wait_clk(79985);
    chk("reset held at start", 6'h1, {5'h0, rst_oe});
    wait_clk(20);
    chk("reset released", 6'h0, {5'h0, rst_oe});
    chk("power-good released", 6'h0, {5'h0, pg_oe});
    chk("open-drain data low", 6'h0, {4'h0, rst_dat, pg_dat});
  endtask
  task automatic t_no_count;
    mon[4] = 1'b1;
    wait_clk(8);
    mon[4] = 1'b0;
    chk("io uv flag", 6'h10, mflag);
    chk("counter after flag fault", 6'h1, {2'h0, cnt});
    chk("reset after uv impact 01", 6'h0, {5'h0, rst_oe});
  endtask
  task automatic t_pg_monitor;
    pg_asgn = 3'h1;
    mon[3] = 1'b1;
    wait_clk(8);
    mon[3] = 1'b0;
    chk("power-good on core uv", 6'h1, {5'h0, pg_oe});
    chk("reset with power-good", 6'h1, {5'h0, rst_oe});
    chk("counter on core uv", 6'h1, {2'h0, cnt});
    wait_clk(8);
    pg_asgn = 3'h0;
    chk("power-good after core uv", 6'h0, {5'h0, pg_oe});
    chk("reset after core uv", 6'h0, {5'h0, rst_oe});
  endtask
  task automatic t_request;
    req = 1'b1;
    wait_clk(4);
    req = 1'b0;
    chk("reset on request", 6'h1, {5'h0, rst_oe});
    chk("power-good on request", 6'h0, {5'h0, pg_oe});
    chk("counter on request", 6'h1, {2'h0, cnt});
    stuck = 1'b1;
    wait_clk(8100);
    stuck = 1'b0;
    chk("short-high flag", 6'h1, {5'h0, sh_flag});
    chk("counter after short", 6'h2, {2'h0, cnt});
    wait_clk(1396);
    chk("pulse still low", 6'h1, {5'h0, rst_oe});
    wait_clk(600);
    chk("pulse ended", 6'h0, {5'h0, rst_oe});
  endtask
  task automatic t_ext_low;
    pull = 1'b1;
    wait_clk(10);
    chk("ext reset flag", 6'h1, {5'h0, xflag});
    chk("counter on ext low", 6'h3, {2'h0, cnt});
    chk("power-good on ext low", 6'h0, {5'h0, pg_oe});
    pull = 1'b0;
    wait_clk(8);
    chk("counter after ext low", 6'h3, {2'h0, cnt});
    chk("reset after ext low", 6'h0, {5'h0, rst_oe});
  endtask
  task automatic t_corrupt;
    for (int i = 4; i <= 8; i++) begin
      reg_cor = i[0];
      prom_cor = !i[0];
      wait_clk(6);
      reg_cor = 1'b0;
      prom_cor = 1'b0;
      chk("counter on corruption", i[5:0], {2'h0, cnt});
      chk("deep at limit", {5'h0, i == 8}, {5'h0, deep});
      if (i < 8) begin
        chk("reset on corruption", 6'h0, {5'h0, rst_oe});
        chk("power-good on corruption", 6'h0, {5'h0, pg_oe});
      end
      wait_clk(3);
    end
  endtask
  initial begin
    t_startup();
    t_no_count();
    t_pg_monitor();
    t_request();
    t_ext_low();
    t_corrupt();
    stop_test();
  end
endmodule

/* ffr_fault_ctrl.sv */
// Fail-safe fault counter and reset/power-good control.
// Functional notes
// [RULE1] After release, counted reset faults add one.
// [RULE2] Non-reset faults only set their flag.
// [RULE3] Monitor reset reaction follows impact bit one.
// [RULE4] External reset low counts, asserts reset; code counts but leaves reset undriven in FFR_ST_EXTLOW.
// [RULE5] Host pulse request asserts reset, no count.
// [RULE6] Reset stuck high 650us flags and counts.
// [RULE7] Corruption flags count without asserting outputs.
// [RULE8] Coupling bit makes reset faults assert power-good.
// [RULE9] Counter starts at one after reset, standby.
// [RULE10] Counter at maximum enters deep fail-safe.
// [RULE11] Limit field selects 2, 6, 8, 12.
// [RULE12] Power-good asserted always implies reset asserted.
// [RULE13] Assigned monitor fault drives power-good and reset.
// [RULE14] Reset low eight seconds enters deep fail-safe.
// [RULE15] Duration bit selects long or short pulse.
// [RULE16] Reset released eight ms after start-up.
// [RULE17] Impact field 1x asserts reset, else none.
// [RULE18] Compare after increment; equal enters deep state.
module ffr_fault_ctrl (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic failsafe_init_phase_in,
  input wire logic cfg_write_in,
  input wire logic [1:0] fault_counter_max_sel_in,
  input wire logic [1:0] core_ov_reset_impact_in,
  input wire logic [1:0] core_uv_reset_impact_in,
  input wire logic [1:0] io_ov_reset_impact_in,
  input wire logic [1:0] io_uv_reset_impact_in,
  input wire logic [1:0] aux_ov_reset_impact_in,
  input wire logic [1:0] aux_uv_reset_impact_in,
  input wire logic reset_pulse_length_sel_in,
  input wire logic pg_reset_coupling_in,
  input wire logic [2:0] pg_assign_in,
  input wire logic [5:0] monitor_fault_in,
  input wire logic register_corrupt_flag_in,
  input wire logic prom_corrupt_flag_in,
  input wire logic reset_request_in,
  input wire logic standby_resume_in,
  input wire logic reset_pin_in,
  output logic reset_out_n_out,
  output logic reset_out_n_oe_out,
  output logic power_good_n_out,
  output logic power_good_n_oe_out,
  output logic [3:0] fault_counter_out,
  output logic [1:0] fault_counter_max_sel_out,
  output logic [5:0] monitor_flag_out,
  output logic short_high_flag_out,
  output logic ext_reset_flag_out,
  output logic deep_failsafe_state_out
);
  import ffr_pkg::*;

  // ----------------------------------------
  // Functions.
  // ----------------------------------------
  function automatic logic [3:0] max_of(input logic [1:0] sel);
    case (sel)
      2'h0: max_of = FFR_MAX_2;
      2'h1: max_of = FFR_MAX_6;
      2'h2: max_of = FFR_MAX_8;
      default: max_of = FFR_MAX_12;
    endcase
  endfunction

  function automatic logic rising(input logic now, input logic prev);
    rising = now && !prev;
  endfunction

  // ----------------------------------------
  // Pin synchronisers.
  // ----------------------------------------
  logic [5:0] mon_s1_reg;
  logic [5:0] mon_s2_reg;
  logic [5:0] mon_d_reg;
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_d_reg;
  logic reg_c_s1_reg;
  logic reg_c_s2_reg;
  logic reg_c_d_reg;
  logic otp_c_s1_reg;
  logic otp_c_s2_reg;
  logic otp_c_d_reg;
  logic req_d_reg;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      mon_s1_reg <= '0;
      mon_s2_reg <= '0;
      mon_d_reg <= '0;
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_d_reg <= 1'b0;
      reg_c_s1_reg <= 1'b0;
      reg_c_s2_reg <= 1'b0;
      reg_c_d_reg <= 1'b0;
      otp_c_s1_reg <= 1'b0;
      otp_c_s2_reg <= 1'b0;
      otp_c_d_reg <= 1'b0;
      req_d_reg <= 1'b0;
    end else begin
      mon_s1_reg <= monitor_fault_in;
      mon_s2_reg <= mon_s1_reg;
      mon_d_reg <= mon_s2_reg;
      pin_s1_reg <= reset_pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg <= pin_s2_reg;
      reg_c_s1_reg <= register_corrupt_flag_in;
      reg_c_s2_reg <= reg_c_s1_reg;
      reg_c_d_reg <= reg_c_s2_reg;
      otp_c_s1_reg <= prom_corrupt_flag_in;
      otp_c_s2_reg <= otp_c_s1_reg;
      otp_c_d_reg <= otp_c_s2_reg;
      req_d_reg <= reset_request_in;
    end
  end

  // ----------------------------------------
  // Configuration registers.
  // ----------------------------------------
  logic [1:0] max_sel_reg;
  logic [11:0] impact_reg;
  logic cfg_we;
  assign cfg_we = cfg_write_in && failsafe_init_phase_in;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      max_sel_reg <= FFR_MAX_SEL_RESET; // [RULE11]
      impact_reg <= {FFR_UV_IMPACT_RESET, FFR_UV_IMPACT_RESET, FFR_UV_IMPACT_RESET,
                     FFR_OV_IMPACT_RESET, FFR_OV_IMPACT_RESET, FFR_OV_IMPACT_RESET}; // [RULE17]
    end else if (cfg_we) begin
      max_sel_reg <= fault_counter_max_sel_in;
      impact_reg <= {aux_uv_reset_impact_in, io_uv_reset_impact_in, core_uv_reset_impact_in,
                     aux_ov_reset_impact_in, io_ov_reset_impact_in, core_ov_reset_impact_in};
    end
  end

  // ----------------------------------------
  // Fault decode.
  // ----------------------------------------
  // Monitor order: core ov, io ov, aux ov, core uv, io uv, aux uv.
  logic [5:0] mon_rise;
  logic [5:0] mon_rst_en;
  logic [2:0] pg_mon_fault;
  logic pg_fault;
  logic mon_rst_event;
  logic internal_event;

  genvar gi;
  generate
    for (gi = 0; gi < FFR_NMON; gi++) begin : g_mon
      assign mon_rise[gi] = rising(mon_s2_reg[gi], mon_d_reg[gi]);
      assign mon_rst_en[gi] = impact_reg[2*gi+FFR_IMPACT_RST_BIT]; // [RULE3] [RULE17]
    end
  endgenerate

  assign pg_mon_fault = pg_assign_in & (mon_s2_reg[2:0] | mon_s2_reg[5:3]);
  assign pg_fault = |pg_mon_fault; // [RULE13]
  assign mon_rst_event = |(mon_rise & mon_rst_en); // [RULE1] [RULE2]
  assign internal_event = rising(reg_c_s2_reg, reg_c_d_reg) || rising(otp_c_s2_reg, otp_c_d_reg); // [RULE7]

  // ----------------------------------------
  // Timers.
  // ----------------------------------------
  ffr_timer_if pulse_t ();
  ffr_timer_if short_t ();
  ffr_timer_if stuck_t ();
  ffr_timer u_pulse (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .t(pulse_t.tmr));
  ffr_timer u_short (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .t(short_t.tmr));
  ffr_timer u_stuck (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .t(stuck_t.tmr));

  // ----------------------------------------
  // State machine.
  // ----------------------------------------
  ffr_state_e state_reg;
  ffr_state_e state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] cnt_inc;
  logic drive_low_reg;
  logic drive_low_next;
  logic pg_low_reg;
  logic pg_low_next;
  logic short_flag_reg;
  logic ext_flag_reg;
  logic [5:0] mon_flag_reg;
  logic pulse_long_reg;
  logic pulse_long_next;
  logic pg_hold_reg;
  logic pg_hold_next;
  logic ext_low;
  logic short_high;
  logic rst_fault;
  logic count_event;

  // ----------------------------------------
  // Event edges.
  // ----------------------------------------
  logic short_exp_d_reg;
  logic short_event;
  logic pin_fall;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      short_exp_d_reg <= 1'b0;
    end else begin
      short_exp_d_reg <= short_t.expired;
    end
  end

  // The stuck-high timer holds its expiry, so only its first cycle counts.
  assign short_event = rising(short_t.expired, short_exp_d_reg); // [RULE6]
  // Our own drive of reset, still echoing through the pipeline, is no external low.
  assign pin_fall = rising(pin_d_reg, pin_s2_reg) && !drive_low_reg && !reset_out_n_oe_out;

  assign ext_low = (state_reg == FFR_ST_RUN) && pin_fall; // [RULE4]
  assign short_high = drive_low_reg && pin_s2_reg;
  assign rst_fault = (state_reg == FFR_ST_RUN) && mon_rst_event; // [RULE1]
  assign count_event = rst_fault || ext_low || short_event || internal_event;
  assign cnt_inc = cnt_reg + 4'h1;

  assign short_t.run = short_high;
  assign short_t.limit = FFR_TMR_W'(FFR_SHORT_HIGH_CYC); // [RULE6]
  assign stuck_t.run = !pin_s2_reg && (state_reg != FFR_ST_DEEP);
  assign stuck_t.limit = FFR_TMR_W'(FFR_STUCK_LOW_CYC); // [RULE14]
  assign pulse_t.run = (state_reg == FFR_ST_STARTUP) || (state_reg == FFR_ST_RESET);
  assign pulse_t.limit = (state_reg == FFR_ST_STARTUP) ? FFR_TMR_W'(FFR_RELEASE_CYC) :
                         (pulse_long_reg ? FFR_TMR_W'(FFR_LONG_PULSE_CYC) :
                          FFR_TMR_W'(FFR_SHORT_PULSE_CYC)); // [RULE15] [RULE16]

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pulse_long_next = pulse_long_reg;
    pg_hold_next = pg_hold_reg;
    if (count_event && state_reg != FFR_ST_DEEP) begin
      cnt_next = cnt_inc; // [RULE1] [RULE4] [RULE6] [RULE7]
    end
    case (state_reg)
      FFR_ST_STARTUP: begin
        if (pulse_t.expired) begin
          state_next = FFR_ST_RUN; // [RULE16]
        end
      end
      FFR_ST_RUN: begin
        pulse_long_next = reset_pulse_length_sel_in;
        pg_hold_next = 1'b0;
        if (ext_low) begin
          state_next = FFR_ST_EXTLOW; // [RULE4]
        end else if (rst_fault) begin
          state_next = FFR_ST_RESET;
          pg_hold_next = pg_reset_coupling_in; // [RULE8]
        end else if (rising(reset_request_in, req_d_reg)) begin
          state_next = FFR_ST_RESET; // [RULE5]
        end
      end
      FFR_ST_RESET: begin
        if (pulse_t.expired) begin
          state_next = FFR_ST_RUN;
        end
      end
      FFR_ST_EXTLOW: begin
        if (pin_s2_reg) begin
          state_next = FFR_ST_RUN;
        end
      end
      FFR_ST_DEEP: begin
        state_next = FFR_ST_DEEP;
      end
      default: begin
        state_next = FFR_ST_STARTUP;
      end
    endcase
    if (standby_resume_in) begin
      state_next = FFR_ST_STARTUP;
      cnt_next = FFR_CNT_RESET; // [RULE9]
    end
    if (state_reg != FFR_ST_DEEP && ((count_event && cnt_inc == max_of(max_sel_reg)) || stuck_t.expired)) begin
      state_next = FFR_ST_DEEP; // [RULE10] [RULE14] [RULE18]
    end
  end

  assign pg_low_next = (state_next != FFR_ST_RUN && state_next != FFR_ST_EXTLOW
                        && state_next != FFR_ST_RESET) || pg_fault || pg_hold_next; // [RULE13] [RULE8]
  assign drive_low_next = pg_low_next || state_next == FFR_ST_RESET; // [RULE12] [RULE5]

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_reg <= FFR_ST_STARTUP;
      cnt_reg <= FFR_CNT_RESET; // [RULE9]
      pulse_long_reg <= 1'b0;
      pg_hold_reg <= 1'b0;
      drive_low_reg <= 1'b1;
      pg_low_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pulse_long_reg <= pulse_long_next;
      pg_hold_reg <= pg_hold_next;
      drive_low_reg <= drive_low_next;
      pg_low_reg <= pg_low_next;
    end
  end

  // ----------------------------------------
  // Diagnostic flags; a new event wins over a clear.
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      mon_flag_reg <= '0;
      short_flag_reg <= 1'b0;
      ext_flag_reg <= 1'b0;
    end else begin
      mon_flag_reg <= (standby_resume_in ? 6'h00 : mon_flag_reg) | mon_rise; // [RULE2]
      short_flag_reg <= (!standby_resume_in && short_flag_reg) | short_t.expired; // [RULE6]
      ext_flag_reg <= (!standby_resume_in && ext_flag_reg) | ext_low;
    end
  end

  // ----------------------------------------
  // Outputs.
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      reset_out_n_out <= 1'b0;
      reset_out_n_oe_out <= 1'b1;
      power_good_n_out <= 1'b0;
      power_good_n_oe_out <= 1'b1;
      fault_counter_out <= FFR_CNT_RESET;
      fault_counter_max_sel_out <= FFR_MAX_SEL_RESET;
      monitor_flag_out <= '0;
      short_high_flag_out <= 1'b0;
      ext_reset_flag_out <= 1'b0;
      deep_failsafe_state_out <= 1'b0;
    end else begin
      reset_out_n_out <= 1'b0;
      reset_out_n_oe_out <= drive_low_reg;
      power_good_n_out <= 1'b0;
      power_good_n_oe_out <= pg_low_reg;
      fault_counter_out <= cnt_reg;
      fault_counter_max_sel_out <= max_sel_reg;
      monitor_flag_out <= mon_flag_reg;
      short_high_flag_out <= short_flag_reg;
      ext_reset_flag_out <= ext_flag_reg;
      deep_failsafe_state_out <= (state_reg == FFR_ST_DEEP);
    end
  end
endmodule

/* ffr_fault_ctrl_assertions.sv */
// Concurrent checks on the ports of the fault reaction block.
module ffr_fault_ctrl_assertions (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic failsafe_init_phase_in,
  input wire logic pg_reset_coupling_in,
  input wire logic [2:0] pg_assign_in,
  input wire logic [5:0] monitor_fault_in,
  input wire logic reset_request_in,
  input wire logic reset_pin_in,
  input wire logic reset_out_n_oe_out,
  input wire logic power_good_n_oe_out,
  input wire logic [3:0] fault_counter_out,
  input wire logic [1:0] fault_counter_max_sel_out,
  input wire logic short_high_flag_out,
  input wire logic ext_reset_flag_out,
  input wire logic deep_failsafe_state_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import ffr_pkg::*;
  logic [3:0] max_val;
  logic [16:0] low_cnt_reg;
  logic [15:0] hi_cnt_reg;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  assign max_val = (fault_counter_max_sel_out == 2'h0) ? FFR_MAX_2 : (fault_counter_max_sel_out == 2'h1) ? FFR_MAX_6 :
                   (fault_counter_max_sel_out == 2'h2) ? FFR_MAX_8 : FFR_MAX_12;
  // ----------------------------------------
  // Cycles of driven reset, and of driven reset read back high.
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      low_cnt_reg <= 17'h0_0000;
      hi_cnt_reg <= 16'h0000;
    end else begin
      low_cnt_reg <= (reset_out_n_oe_out && low_cnt_reg != 17'h1_ffff) ? low_cnt_reg + 17'h0_0001 : 17'h0_0000;
      hi_cnt_reg <= (reset_out_n_oe_out && reset_pin_in && hi_cnt_reg != 16'hffff) ? hi_cnt_reg + 16'h0001 :
                    16'h0000;
    end
  end
  sequence s_request;
    $rose(reset_request_in) && !reset_out_n_oe_out && !deep_failsafe_state_out;
  endsequence
  sequence s_quiet_request;
    s_request ##0 (!pg_reset_coupling_in && monitor_fault_in == 6'h00);
  endsequence
  a_pg_over_reset: assert property (power_good_n_oe_out |-> reset_out_n_oe_out)
    else $error("power-good driven without reset");
  a_count_step: assert property ($changed(fault_counter_out) |->
    fault_counter_out == $past(fault_counter_out) + 4'h1 || fault_counter_out == FFR_CNT_RESET)
    else $error("fault counter moved by other than one");
  a_count_bounded: assert property (!deep_failsafe_state_out |-> fault_counter_out <= max_val)
    else $error("fault counter beyond its limit");
  a_deep_at_max: assert property (fault_counter_out == max_val |-> ##[0:3] deep_failsafe_state_out)
    else $error("limit reached without deep state");
  a_deep_sticky: assert property (deep_failsafe_state_out |=> deep_failsafe_state_out)
    else $error("deep state left");
  a_cfg_hold: assert property (!failsafe_init_phase_in [*2] |=> $stable(fault_counter_max_sel_out))
    else $error("limit select changed outside init");
  a_request_resets: assert property (s_request |-> ##[1:4] reset_out_n_oe_out)
    else $error("request did not drive reset");
  a_request_no_count: assert property (s_quiet_request |=> $stable(fault_counter_out) [*4])
    else $error("request changed counter");
  a_request_no_pg: assert property (s_quiet_request |=> !power_good_n_oe_out [*4])
    else $error("request drove power-good");
  a_pulse_min: assert property ($fell(reset_out_n_oe_out) && !$past(power_good_n_oe_out) |->
    ext_reset_flag_out || low_cnt_reg >= 17'h0_2328)
    else $error("reset pulse too short");
  a_ext_no_pg: assert property ($rose(ext_reset_flag_out) |-> !power_good_n_oe_out)
    else $error("external reset low drove power-good");
  a_short_flag: assert property (hi_cnt_reg == 16'h1f54 |-> short_high_flag_out)
    else $error("stuck-high reset not flagged");
  a_short_early: assert property ($rose(short_high_flag_out) |-> hi_cnt_reg >= 16'h1388)
    else $error("stuck-high flag too early");
  a_pg_monitor: assert property (pg_assign_in[0] && (monitor_fault_in[0] || monitor_fault_in[3]) [*8] |->
    power_good_n_oe_out && reset_out_n_oe_out)
    else $error("assigned monitor fault left power-good released");
endmodule
bind ffr_fault_ctrl ffr_fault_ctrl_assertions chk (.clk_sys_in, .rst_n_in, .failsafe_init_phase_in,
  .pg_reset_coupling_in, .pg_assign_in, .monitor_fault_in, .reset_request_in, .reset_pin_in, .reset_out_n_oe_out,
  .power_good_n_oe_out, .fault_counter_out, .fault_counter_max_sel_out, .short_high_flag_out, .ext_reset_flag_out,
  .deep_failsafe_state_out);

/* ffr_host_model.sv */
// Model of the host side of the open-drain reset line.
module ffr_host_model (
  input wire logic reset_oe_in,
  input wire logic stuck_high_in,
  input wire logic ext_pull_in,
  output logic reset_line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-up wins when released; a short to high overrides the pull-down; an external pull-down wins over all.
  assign reset_line_out = (stuck_high_in | ~reset_oe_in) & ~ext_pull_in;
endmodule

/* ffr_pkg.sv */
// Package of constants and types for the fail-safe fault reaction block.
package ffr_pkg;
  // ----------------------------------------
  // Timing.
  // ----------------------------------------
  localparam int unsigned FFR_CLK_HZ = 10000000;
  localparam int unsigned FFR_SHORT_HIGH_US = 650;
  localparam int unsigned FFR_SHORT_HIGH_CYC = FFR_SHORT_HIGH_US * (FFR_CLK_HZ / 1000000);
  localparam int unsigned FFR_LONG_PULSE_US = 10000;
  localparam int unsigned FFR_LONG_PULSE_CYC = FFR_LONG_PULSE_US * (FFR_CLK_HZ / 1000000);
  localparam int unsigned FFR_SHORT_PULSE_US = 1000;
  localparam int unsigned FFR_SHORT_PULSE_CYC = FFR_SHORT_PULSE_US * (FFR_CLK_HZ / 1000000);
  localparam int unsigned FFR_STUCK_LOW_MS = 8000;
  localparam int unsigned FFR_STUCK_LOW_CYC = FFR_STUCK_LOW_MS * (FFR_CLK_HZ / 1000);
  localparam int unsigned FFR_RELEASE_MS = 8;
  localparam int unsigned FFR_RELEASE_CYC = FFR_RELEASE_MS * (FFR_CLK_HZ / 1000);
  localparam int unsigned FFR_TMR_W = 27;
  // ----------------------------------------
  // Counter and configuration.
  // ----------------------------------------
  localparam logic [3:0] FFR_CNT_RESET = 4'h1;
  localparam logic [1:0] FFR_MAX_SEL_RESET = 2'h1;
  localparam logic [1:0] FFR_OV_IMPACT_RESET = 2'h2;
  localparam logic [1:0] FFR_UV_IMPACT_RESET = 2'h1;
  localparam int unsigned FFR_IMPACT_RST_BIT = 1;
  localparam logic [3:0] FFR_MAX_2 = 4'h2;
  localparam logic [3:0] FFR_MAX_6 = 4'h6;
  localparam logic [3:0] FFR_MAX_8 = 4'h8;
  localparam logic [3:0] FFR_MAX_12 = 4'hc;
  localparam int unsigned FFR_NMON = 6;

  typedef enum logic [2:0] {
    FFR_ST_STARTUP = 3'b000,
    FFR_ST_RUN = 3'b001,
    FFR_ST_RESET = 3'b010,
    FFR_ST_EXTLOW = 3'b011,
    FFR_ST_DEEP = 3'b100
  } ffr_state_e;
endpackage

/* ffr_timer.sv */
// Cycle timer that counts while enabled and flags reaching its limit.
module ffr_timer (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  ffr_timer_if.tmr t
);
  import ffr_pkg::*;
  logic [FFR_TMR_W-1:0] cnt_reg;
  logic [FFR_TMR_W-1:0] cnt_next;
  logic hit;
  assign hit = (cnt_reg >= t.limit);
  assign cnt_next = !t.run ? '0 : (hit ? cnt_reg : cnt_reg + 1'b1);
  assign t.expired = t.run && hit;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

/* ffr_timer_if.sv */
// Interface carrying run, limit and expiry between the control logic and its timers.
interface ffr_timer_if;
  import ffr_pkg::*;
  logic run;
  logic [FFR_TMR_W-1:0] limit;
  logic expired;
  modport ctrl(output run, output limit, input expired);
  modport tmr(input run, input limit, output expired);
endinterface
